/* File: verilog/dbg_host_defs.vh */
`ifndef DBG_HOST_DEFS_VH
`define DBG_HOST_DEFS_VH
// ---------------------------------------------------------------
// link framing
// ---------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define CYCLES_PER_BYTE 4'h9
`define ADDR_W 7
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
// ---------------------------------------------------------------
// device address limits
// ---------------------------------------------------------------
`define WR_ADDR_END 7'h30
`define RD_ADDR_END 7'h20
// ---------------------------------------------------------------
// timing: half period of the serial clock in system cycles, its counter width; read buffer depth
// ---------------------------------------------------------------
`define HALF_PERIOD_DEF 8
`define CNT_W 8
`define FIFO_DEPTH_LOG 1
`endif

/* File: verilog/byte_buffer.v */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// two-entry buffer, registered read data
// ---------------------------------------------------------------
module byte_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH_LOG = 1
) (
  input wire clk,
  input wire arst_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid_reg,
  input wire outReady,
  output reg [WIDTH-1:0] outData_reg
);
  localparam DEPTH = 1 << DEPTH_LOG;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG:0] wrPtr_reg;
  reg [DEPTH_LOG:0] rdPtr_reg;
  wire [DEPTH_LOG:0] fill;
  wire doWrite;
  wire doRead;
  assign fill = wrPtr_reg - rdPtr_reg;
  // the output register holds one more word beyond the two entries
  assign inReady = (fill < DEPTH[DEPTH_LOG:0]);
  assign doWrite = inValid && inReady;
  assign doRead = (fill != {(DEPTH_LOG+1){1'b0}}) && (!outValid_reg || outReady);
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg[DEPTH_LOG-1:0]] <= inData;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= {(DEPTH_LOG+1){1'b0}};
      rdPtr_reg <= {(DEPTH_LOG+1){1'b0}};
      outValid_reg <= 1'b0;
      outData_reg <= {WIDTH{1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
        outData_reg <= mem[rdPtr_reg[DEPTH_LOG-1:0]];
        outValid_reg <= 1'b1;
      end else if (outReady) begin
        outValid_reg <= 1'b0;
      end
    end
  end
endmodule // byte_buffer

/* File: verilog/debug_link_master.v */
// Function
// - master alone starts transfers, drives clock
// - data changes only while clock low
// - start: data falls while clock high
// - bytes sent msb first
// - nine clock cycles per byte
// - finish: stop in ninth cycle, clock high
// - separator high before next start
// - separator low through command for bus
// - address, direction, separator after start
// - single write: eight data edges then stop
// - clock at most 0.4 fsys, long low
`timescale 1ns/1ns
`include "dbg_host_defs.vh"
module debug_link_master #(
  parameter HALF_PERIOD = `HALF_PERIOD_DEF
) (
  input wire clk,
  input wire arst_n,
  input wire cmdValid,
  output reg cmdReady_reg,
  input wire [6:0] cmdAddr,
  input wire cmdRead,
  input wire [7:0] cmdCount,
  input wire cmdHoldBus,
  input wire wrValid,
  output reg wrReady_reg,
  input wire [7:0] wrData,
  output wire rdValid,
  input wire rdReady,
  output wire [7:0] rdData,
  output reg busy_reg,
  output reg sclOut_reg,
  input wire sdaIn,
  output reg sdaOut_reg,
  output reg sdaOe_reg
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam S_IDLE = 5'h01;
  localparam S_START = 5'h02;
  localparam S_SHIFT = 5'h04;
  localparam S_LOAD = 5'h08;
  localparam S_END = 5'h10;
  reg [4:0] state_reg;
  reg [`CNT_W-1:0] tick_reg;
  reg phase_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg isAddr_reg;
  reg dirRead_reg;
  reg holdBus_reg;
  reg dataDue_reg;
  reg [7:0] left_reg;
  reg sdaMeta_reg;
  reg sdaSync_reg;
  reg bufValid_reg;
  reg [7:0] bufData_reg;
  wire bufReady;
  wire tick;
  wire lastByte;
  wire readPhase;
  // ---------------------------------------------------------------
  // bit-rate divider
  // ---------------------------------------------------------------
  // half period >= 2 keeps clock <= 0.25 fsys, low phase >= 2 cycles
  assign tick = (tick_reg == HALF_PERIOD[`CNT_W-1:0] - 1'b1);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= {`CNT_W{1'b0}};
    end else if (tick || state_reg == S_IDLE) begin
      tick_reg <= {`CNT_W{1'b0}};
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // data input synchroniser
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
    end else begin
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
    end
  end
  assign lastByte = (left_reg == 8'h01);
  assign readPhase = dirRead_reg && !isAddr_reg && bitCnt_reg < `BITS_PER_BYTE;
  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      phase_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      isAddr_reg <= 1'b0;
      dirRead_reg <= 1'b0;
      holdBus_reg <= 1'b0;
      dataDue_reg <= 1'b0;
      left_reg <= 8'h00;
      cmdReady_reg <= 1'b0;
      wrReady_reg <= 1'b0;
      busy_reg <= 1'b0;
      sclOut_reg <= 1'b1;
      sdaOut_reg <= 1'b1;
      sdaOe_reg <= 1'b1;
      bufValid_reg <= 1'b0;
      bufData_reg <= 8'h00;
    end else begin
      cmdReady_reg <= 1'b0;
      wrReady_reg <= 1'b0;
      dataDue_reg <= 1'b0;
      if (bufValid_reg && bufReady) begin
        bufValid_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          sclOut_reg <= 1'b1;
          sdaOut_reg <= 1'b1;
          sdaOe_reg <= 1'b1;
          if (cmdValid && !cmdReady_reg && cmdCount != 8'h00) begin
            cmdReady_reg <= 1'b1;
            busy_reg <= 1'b1;
            shift_reg <= {cmdAddr, cmdRead};
            dirRead_reg <= cmdRead;
            holdBus_reg <= cmdHoldBus;
            left_reg <= cmdCount;
            isAddr_reg <= 1'b1;
            bitCnt_reg <= 4'h0;
            phase_reg <= 1'b0;
            state_reg <= S_START;
          end
        end
        S_START: begin
          if (tick) begin
            sdaOut_reg <= 1'b0;
            state_reg <= S_SHIFT;
          end
        end
        S_LOAD: begin
          // stall with clock high after the separator until the next write byte arrives
          if (wrValid) begin
            wrReady_reg <= 1'b1;
            shift_reg <= wrData;
            state_reg <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          // data moves one cycle after the clock fell, so a falling data
          // edge can never meet a clock still seen high (false start)
          if (dataDue_reg) begin
            if (bitCnt_reg < `BITS_PER_BYTE) begin
              sdaOut_reg <= shift_reg[7];
            end else begin
              // separator high on the last byte, or after every byte when the bus is not held
              sdaOut_reg <= (!isAddr_reg && lastByte) || !holdBus_reg;
            end
          end
          if (tick) begin
            phase_reg <= !phase_reg;
            if (!phase_reg) begin
              sclOut_reg <= 1'b0;
              dataDue_reg <= 1'b1;
              if (bitCnt_reg < `BITS_PER_BYTE) begin
                sdaOe_reg <= !readPhase;
              end else begin
                sdaOe_reg <= 1'b1;
              end
            end else if (!bufValid_reg || bufReady || !readPhase) begin
              sclOut_reg <= 1'b1;
              if (bitCnt_reg < `BITS_PER_BYTE) begin
                shift_reg <= {shift_reg[6:0], readPhase ? sdaSync_reg : 1'b0};
                bitCnt_reg <= bitCnt_reg + 1'b1;
              end else begin
                bitCnt_reg <= 4'h0;
                if (!isAddr_reg && lastByte) begin
                  state_reg <= S_END;
                end else begin
                  if (!isAddr_reg) begin
                    left_reg <= left_reg - 1'b1;
                  end
                  isAddr_reg <= 1'b0;
                  if (!dirRead_reg) begin
                    state_reg <= S_LOAD;
                  end
                end
              end
              if (readPhase && bitCnt_reg == `BITS_PER_BYTE - 1'b1) begin
                bufValid_reg <= 1'b1;
                bufData_reg <= {shift_reg[6:0], sdaSync_reg};
              end
            end else begin
              phase_reg <= phase_reg;
            end
          end
        end
        S_END: begin
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
  byte_buffer #(
    .WIDTH(8),
    .DEPTH_LOG(`FIFO_DEPTH_LOG)
  ) rdBuf (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(bufValid_reg),
    .inReady(bufReady),
    .inData(bufData_reg),
    .outValid_reg(rdValid),
    .outReady(rdReady),
    .outData_reg(rdData)
  );
endmodule // debug_link_master

/* File: bench/debug_link_checker.sv */
`timescale 1ns/1ns
module debug_link_checker (
  input wire clk,
  input wire arst_n,
  input wire cmdValid,
  input wire cmdReady_reg,
  input wire wrReady_reg,
  input wire rdValid,
  input wire rdReady,
  input wire [7:0] rdData,
  input wire busy_reg,
  input wire sclOut_reg,
  input wire sdaOut_reg,
  input wire sdaOe_reg
);
  // ----
  // port timing
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  cmd_pulse_a: assert property (cmdReady_reg |=> !cmdReady_reg)
    else $error("cmd ready too long");
  busy_follow_a: assert property (cmdReady_reg |-> ##[0:1] busy_reg)
    else $error("busy missing");
  busy_cause_a: assert property ($rose(busy_reg) |-> $past(cmdValid))
    else $error("busy without cmd");
  scl_only_busy_a: assert property ($changed(sclOut_reg) |-> busy_reg || $past(busy_reg))
    else $error("clock moved idle");
  start_in_cmd_a: assert property ($fell(sdaOut_reg) && sclOut_reg && $past(sclOut_reg)
    && sdaOe_reg && $past(sdaOe_reg) |-> busy_reg) else $error("start outside cmd");
  scl_idle_a: assert property (!busy_reg |-> sclOut_reg)
    else $error("clock low idle");
  low_phase_a: assert property ($fell(sclOut_reg) |=> !sclOut_reg)
    else $error("low phase short");
  high_phase_a: assert property ($rose(sclOut_reg) |=> sclOut_reg)
    else $error("high phase short");
  release_busy_a: assert property (!sdaOe_reg |-> busy_reg)
    else $error("data released idle");
  wr_pulse_a: assert property (wrReady_reg |=> !wrReady_reg)
    else $error("wr ready too long");
  data_low_a: assert property ($changed(sdaOut_reg) && sdaOe_reg |-> $stable(sclOut_reg)
    && (!sclOut_reg || $fell(sdaOut_reg))) else $error("data moved with clock high");
  end_sep_high_a: assert property ($fell(busy_reg) |-> sdaOut_reg && sdaOe_reg && sclOut_reg)
    else $error("command ended low");
  rd_hold_a: assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
    else $error("read word lost");
endmodule // debug_link_checker
bind debug_link_master debug_link_checker i_chk (.clk(clk), .arst_n(arst_n),
  .cmdValid(cmdValid), .cmdReady_reg(cmdReady_reg), .wrReady_reg(wrReady_reg),
  .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .busy_reg(busy_reg),
  .sclOut_reg(sclOut_reg), .sdaOut_reg(sdaOut_reg), .sdaOe_reg(sdaOe_reg));

/* File: bench/debug_device_model.sv */
`timescale 1ns/1ns
module debug_device_model (
  input wire scl,
  input wire sda,
  output reg drv,
  output reg bitOut
);
  // ----
  // slave: clock is only an input
  // ----
  reg [7:0] sh, outSh;
  reg [6:0] addr;
  reg [3:0] n;
  reg act, first, rd;
  reg [7:0] logD [0:31];
  reg [6:0] logA [0:31];
  reg logS [0:63];
  integer wn, sn;
  reg grant;
  integer pc, acc, edges;
  initial {drv, bitOut, act, first, rd, n, sh, outSh, addr, wn, sn} = 0;
  initial {grant, pc, acc, edges} = 0;
  // peripherals keep running whatever the core does
  always @(posedge scl) edges = edges + 1;
  // rising data with clock high falls through untouched
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    n = 4'h0;
    drv = 1'b0;
    grant = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (n < 4'h8) begin
      sh = {sh[6:0], sda};
      n = n + 4'h1;
    end else begin
      n = 4'h0;
      logS[sn] = sda;
      sn = sn + 1;
      grant = (sda === 1'b1);
      if (first) begin
        {addr, rd} = sh;
        first = 1'b0;
      end else if (!rd) begin
        logA[wn] = addr;
        logD[wn] = sh;
        wn = wn + 1;
        acc = acc + 1;
        if (addr != 7'h30) addr = addr + 7'h1;
      end else begin
        pc = pc + 2;
        acc = acc + 1;
        if (addr != 7'h20) addr = addr + 7'h1;
      end
    end
  end
  always @(negedge scl) if (act && rd && !first) begin
    if (n == 4'h0) outSh = {addr[0], addr};
    drv = (n < 4'h8);
    if (n < 4'h8) bitOut = outSh[4'h7 - n];
  end
endmodule // debug_device_model

/* File: bench/debug_link_master_tb.sv */
`timescale 1ns/1ns
module debug_link_master_tb;
  reg clk, arst_n, cmdValid, cmdRead, cmdHoldBus, wrValid, rdReady, flt;
  reg [6:0] cmdAddr, a;
  reg [7:0] cmdCount, wrData;
  wire cmdReady, wrReady, rdValid, busy, scl, sdaOut, sdaOe, drv, bitOut;
  wire [7:0] rdData;
  // released line shows a toggling pattern, never the last level
  wire sda = sdaOe ? sdaOut : (drv ? bitOut : flt);
  integer n_mismatch, n_tests, k, w0, s0, e0, p0;
  debug_link_master #(.HALF_PERIOD(4)) i_dut (.clk(clk), .arst_n(arst_n), .cmdValid(cmdValid),
    .cmdReady_reg(cmdReady), .cmdAddr(cmdAddr), .cmdRead(cmdRead), .cmdCount(cmdCount),
    .cmdHoldBus(cmdHoldBus), .wrValid(wrValid), .wrReady_reg(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .busy_reg(busy),
    .sclOut_reg(scl), .sdaIn(sda), .sdaOut_reg(sdaOut), .sdaOe_reg(sdaOe));
  debug_device_model i_dev (.scl(scl), .sda(sda), .drv(drv), .bitOut(bitOut));
  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt;
  task report_and_stop;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wait_for(input integer w);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      #1;
      while (((w == 0) ? cmdReady : (w == 1) ? wrReady : (w == 2) ? rdValid : !busy) !== 1'b1) begin
        t = t + 1;
        if (t > 5000) begin
          n_mismatch = n_mismatch + 1;
          $display("BAD %0t wait %0d expired", $time, w);
          report_and_stop;
        end
        @(posedge clk);
        #1;
      end
    end
  endtask
  task cmd(input [6:0] ad, input r, input [7:0] c, input h);
    begin
      @(negedge clk);
      {cmdAddr, cmdRead, cmdCount, cmdHoldBus, cmdValid} = {ad, r, c, h, 1'b1};
      wait_for(0);
      @(negedge clk);
      cmdValid = 1'b0;
    end
  endtask
  task put_byte(input [7:0] d);
    begin
      @(negedge clk);
      {wrValid, wrData} = {1'b1, d};
      wait_for(1);
      @(negedge clk);
      wrValid = 1'b0;
    end
  endtask
  task take_byte(input [7:0] exp);
    begin
      wait_for(2);
      chk(rdData, exp);
      @(negedge clk);
      rdReady = 1'b1;
      @(negedge clk);
      rdReady = 1'b0;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_single_write;
    begin
      {w0, s0} = {i_dev.wn, i_dev.sn};
      {e0, p0} = {i_dev.edges, i_dev.acc};
      cmd(7'h13, 1'b0, 8'h01, 1'b0);
      put_byte(8'ha5);
      wait_for(3);
      chk(i_dev.edges - e0, 8'h12);
      chk(i_dev.acc - p0, 8'h01);
      chk({1'b0, i_dev.logA[w0]}, 8'h13);
      chk(i_dev.logD[w0], 8'ha5);
      chk({7'h00, i_dev.logS[s0]} + i_dev.logS[s0 + 1], 8'h02);
      $display("single write done");
    end
  endtask
  task t_block_write;
    begin
      {w0, s0} = {i_dev.wn, i_dev.sn};
      cmd(7'h2e, 1'b0, 8'h04, 1'b1);
      for (k = 0; k < 4; k = k + 1) put_byte(8'h10 + k[7:0]);
      chk({7'h00, i_dev.grant}, 8'h00);
      wait_for(3);
      chk({7'h00, i_dev.grant}, 8'h01);
      for (k = 0; k < 5; k = k + 1) begin
        a = (k > 2) ? 7'h30 : 7'h2e + k[6:0];
        if (k < 4) chk({1'b0, i_dev.logA[w0 + k]}, {1'b0, a});
        if (k < 4) chk(i_dev.logD[w0 + k], 8'h10 + k[7:0]);
        chk({7'h00, i_dev.logS[s0 + k]}, {7'h00, k == 4});
      end
      $display("block write done");
    end
  endtask
  task t_single_read;
    begin
      p0 = i_dev.pc;
      cmd(7'h13, 1'b1, 8'h01, 1'b0);
      take_byte(8'h93);
      wait_for(3);
      chk(i_dev.pc - p0, 8'h02);
      $display("single read done");
    end
  endtask
  task t_read_stall;
    begin
      // five bytes overrun the read path, so the clock must stall low
      cmd(7'h1e, 1'b1, 8'h05, 1'b0);
      repeat (600) @(negedge clk);
      chk({7'h00, busy}, 8'h01);
      chk({7'h00, scl}, 8'h00);
      for (k = 0; k < 5; k = k + 1) begin
        a = (k > 2) ? 7'h20 : 7'h1e + k[6:0];
        take_byte({a[0], a});
      end
      wait_for(3);
      $display("stalled block read done");
    end
  endtask
  initial begin
    {arst_n, cmdValid, cmdRead, cmdHoldBus, wrValid, rdReady, flt} = 7'h00;
    {cmdAddr, cmdCount, wrData} = 23'h000000;
    {n_mismatch, n_tests} = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_single_write;
    t_block_write;
    t_single_read;
    t_read_stall;
    report_and_stop;
  end
endmodule // debug_link_master_tb
